// [sarro_core.sv]
// conversion control, output coding, parallel and serial result port
// assumes an analog core presenting adc_code on mclk; pins are async
`timescale 1ns/1ns
`include "sarro_params.svh"
module sarro_core #(
   parameter logic [`SARRO_CNT_W-1:0] CONV_CYC = `SARRO_CNT_W'(`SARRO_CONV_CYC),
   parameter logic [`SARRO_CNT_W-1:0] ACQ_CYC  = `SARRO_CNT_W'(`SARRO_ACQ_CYC),
   parameter logic [`SARRO_CNT_W-1:0] PH_CYC   = `SARRO_CNT_W'(`SARRO_PH_CYC)
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   // conversion control pins
   input  wire logic                    conversion_start_n,
   input  wire logic                    power_down_request,
   output logic                         busy,
   output logic                         powered_down,
   // analog core result
   input  wire logic [`SARRO_NBITS-1:0] adc_code,
   // configuration pins
   input  wire logic                    output_coding_select,
   input  wire logic                    serial_parallel_select,
   input  wire logic                    clock_source_select,
   input  wire logic                    serial_clock_invert,
   input  wire logic                    frame_strobe_invert,
   input  wire logic                    read_timing_or_chain_in,
   // read strobes
   input  wire logic                    cs_n,
   input  wire logic                    rd_n,
   // parallel bus
   output logic [`SARRO_NBITS-1:0]      data_out,
   output logic                         data_oe,
   // serial port
   input  wire logic                    sclk_in,
   output logic                         sclk_out,
   output logic                         sclk_oe,
   output logic                         frame_strobe,
   output logic                         serial_data_out,
   output logic                         serial_data_oe,
   output logic                         read_overrun_flag
);
   localparam logic [`SARRO_BITS_W-1:0] LAST = `SARRO_BITS_W'(`SARRO_NBITS - 1);
   localparam logic [`SARRO_BITS_W-1:0] FULL = `SARRO_BITS_W'(`SARRO_NBITS);
   localparam int MSB = `SARRO_NBITS - 1;
   localparam sarro_pkg::sarro_regs_t RST = '{
      st: sarro_pkg::ST_IDLE, s1: '1, s2: '1, s3: '1, default: '0};

   sarro_pkg::sarro_regs_t q;
   sarro_pkg::sarro_regs_t n;

   // ----------------------------------------
   // decoded pin levels and edges
   // ----------------------------------------
   logic                    cnv_l;
   logic                    cnv_fall;
   logic                    ser;
   logic                    master;
   logic                    m_rac;
   logic                    m_rdc;
   logic                    rd_act;
   logic                    sck_r;
   logic                    sck_f;
   logic                    conv_end;
   logic                    mwrap;
   logic                    mdone;
   logic [`SARRO_NBITS-1:0] coded;
   logic [`SARRO_PIN_N-1:0] pins;

   assign pins = {frame_strobe_invert, serial_clock_invert, output_coding_select,
                  clock_source_select, serial_parallel_select, power_down_request,
                  read_timing_or_chain_in, sclk_in, rd_n, cs_n, conversion_start_n};
   assign cnv_l    = ~q.s2[`SARRO_I_CNV];
   assign cnv_fall = q.s3[`SARRO_I_CNV] & cnv_l;
   assign ser      = q.s2[`SARRO_I_SER];
   assign master   = ser & ~q.s2[`SARRO_I_EXT];
   assign m_rac    = master & ~q.s2[`SARRO_I_CHN];
   assign m_rdc    = master & q.s2[`SARRO_I_CHN];
   assign rd_act   = ser & q.s2[`SARRO_I_EXT] & ~q.s2[`SARRO_I_CS] & ~q.s2[`SARRO_I_RD];
   assign sck_r    = ~q.s3[`SARRO_I_SCK] & q.s2[`SARRO_I_SCK];
   assign sck_f    = q.s3[`SARRO_I_SCK] & ~q.s2[`SARRO_I_SCK];
   assign conv_end = (q.st == sarro_pkg::ST_CONV) && (q.cnt == CONV_CYC - 1'b1);
   // binary when select high, msb flipped for twos complement
   assign coded    = {adc_code[MSB] ^ ~q.s2[`SARRO_I_OCS], adc_code[MSB-1:0]};
   assign mwrap    = q.mact && (q.mdiv == PH_CYC - 1'b1) && (q.mph == 2'd3);
   assign mdone    = mwrap && (q.mbits == LAST);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n     = q;
      n.s1  = pins;
      n.s2  = q.s1;
      n.s3  = q.s2;
      n.err = 1'b0;

      // master serial engine: four phases a bit, data moves in low phase
      if (q.mact) begin
         n.mdiv = q.mdiv + 1'b1;
         if (q.mdiv == PH_CYC - 1'b1) begin
            n.mdiv = '0;
            n.mph  = q.mph + 2'd1;
            if (q.mph == 2'd0) begin
               n.sclk = 1'b1;
            end else if (q.mph == 2'd2) begin
               n.sclk = 1'b0;
            end else if (q.mph == 2'd3) begin
               n.sh    = {q.sh[MSB-1:0], 1'b0};
               n.mbits = q.mbits + 1'b1;
               if (mdone) begin
                  n.mact = 1'b0;
                  n.sync = 1'b0;
               end
            end
         end
      end

      // slave serial engine on the sampled external clock
      if (!rd_act) begin
         n.rise_seen = 1'b0;
      end else begin
         if (sck_r) begin
            n.rise_seen = 1'b1;
            n.chain     = q.rdc_f ? 1'b0 : q.s2[`SARRO_I_CHN];
            if (q.sbits != FULL) begin
               n.sbits = q.sbits + 1'b1;
            end
            if (q.st == sarro_pkg::ST_CONV) begin
               n.rdc_f = 1'b1;
            end
         end
         // a leading fall of an idle-high clock must not shift
         if (sck_f && q.rise_seen) begin
            n.sh = {q.sh[MSB-1:0], q.chain};
         end
      end

      // conversion sequencing
      case (q.st)
         sarro_pkg::ST_IDLE: begin
            if (cnv_fall) begin
               n.st  = sarro_pkg::ST_CONV;
               n.cnt = '0;
            end else if (cnv_l) begin
               n.st  = sarro_pkg::ST_ACQ;
               n.cnt = '0;
            end
         end
         sarro_pkg::ST_ACQ: begin
            if (!cnv_l) begin
               n.st = sarro_pkg::ST_IDLE;
            end else if (q.cnt == ACQ_CYC - 1'b1) begin
               n.st  = sarro_pkg::ST_CONV;
               n.cnt = '0;
            end else begin
               n.cnt = q.cnt + 1'b1;
            end
         end
         sarro_pkg::ST_CONV: begin
            n.cnt = q.cnt + 1'b1;
            if (conv_end) begin
               n.hold  = coded;
               n.sh    = coded;
               n.sbits = '0;
               n.rdc_f = 1'b0;
               n.err   = q.rdc_f && (q.sbits != FULL);
               if (m_rac) begin
                  n.st = sarro_pkg::ST_MSEND;
               end else begin
                  n.st = sarro_pkg::ST_IDLE;
               end
            end
         end
         sarro_pkg::ST_MSEND: begin
            if (mdone) begin
               n.st = sarro_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = sarro_pkg::ST_IDLE;
         end
      endcase

      // master frame start: after conversion, or previous result during it
      if ((conv_end && m_rac) || (n.st == sarro_pkg::ST_CONV &&
          q.st != sarro_pkg::ST_CONV && m_rdc)) begin
         n.sh    = conv_end ? coded : q.hold;
         n.mact  = 1'b1;
         n.mbits = '0;
         n.mph   = '0;
         n.mdiv  = '0;
         n.sclk  = 1'b0;
         n.sync  = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         q <= RST;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign busy              = (q.st == sarro_pkg::ST_CONV) || (q.st == sarro_pkg::ST_MSEND);
   assign powered_down      = q.s2[`SARRO_I_PD] && !busy;
   assign data_out          = q.hold;
   assign data_oe           = ~ser & ~q.s2[`SARRO_I_CS] & ~q.s2[`SARRO_I_RD];
   assign serial_data_out   = q.sh[MSB];
   assign serial_data_oe    = ser & ~q.s2[`SARRO_I_CS] & ~q.s2[`SARRO_I_RD];
   assign sclk_out          = q.sclk ^ q.s2[`SARRO_I_INVC];
   assign sclk_oe           = master;
   assign frame_strobe      = q.sync ^ q.s2[`SARRO_I_INVS];
   assign read_overrun_flag = q.err;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [`SARRO_CNT_W:0] blen;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         blen <= '0;
      end else if (!busy) begin
         blen <= '0;
      end else begin
         blen <= blen + 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence sclk_edge_s;
      q.mact && (q.sclk != n.sclk);
   endsequence
   sequence data_held_s;
      $stable(q.sh) ##1 $stable(q.sh);
   endsequence
   sequence frame_end_s;
      mdone ##1 !q.mact;
   endsequence

   start_busy_a: assert property (
      (q.st == sarro_pkg::ST_IDLE) && cnv_fall |=> busy)
      else $error("start edge did not raise busy");
   conv_len_a: assert property (
      conv_end |-> blen == {1'b0, CONV_CYC - 1'b1})
      else $error("conversion length wrong");
   no_restart_a: assert property (
      (q.st == sarro_pkg::ST_CONV) && cnv_fall && !conv_end |=>
      (q.st == sarro_pkg::ST_CONV) && q.cnt == $past(q.cnt) + 1'b1)
      else $error("conversion restarted");
   auto_start_a: assert property (
      (q.st == sarro_pkg::ST_ACQ) && cnv_l && q.cnt == ACQ_CYC - 1'b1 |=> busy)
      else $error("self-running start missed");
   coding_a: assert property (
      conv_end |=> q.hold == {$past(adc_code[MSB]) ^ ~$past(q.s2[`SARRO_I_OCS]),
                              $past(adc_code[MSB-1:0])})
      else $error("output coding wrong");
   bus_off_a: assert property (
      q.s2[`SARRO_I_CS] || q.s2[`SARRO_I_RD] |-> !data_oe && !serial_data_oe)
      else $error("outputs enabled while deselected");
   frame_msb_a: assert property (
      $rose(q.mact) |-> q.sh == q.hold && q.sync)
      else $error("frame did not start with held result");
   data_stable_a: assert property (
      sclk_edge_s |-> data_held_s)
      else $error("serial data moved at clock edge");
   master_busy_a: assert property (
      (q.st == sarro_pkg::ST_MSEND) |-> q.mact && busy)
      else $error("busy ended before frame sent");
   overrun_a: assert property (
      read_overrun_flag |-> $past(q.rdc_f) && $past(q.sbits) != FULL)
      else $error("spurious read error");
   chain_a: assert property (
      rd_act && sck_f && q.rise_seen && !conv_end |=> q.sh[0] == $past(q.chain))
      else $error("chain bit not shifted in");

   // master frame: sixteen bits of four phases at the default phase length
   frame_len_a: assert property (
      $rose(q.mact) |-> ##255 frame_end_s)
      else $error("master frame length wrong");
   frame_strobe_a: assert property (
      q.mact |-> q.sync && sclk_oe)
      else $error("strobe or clock drive missing in frame");
   sclk_rest_a: assert property (
      !q.mact |-> !q.sclk && !q.sync)
      else $error("serial clock or strobe not at rest");
   rdc_frame_a: assert property (
      $rose(busy) && m_rdc |-> q.mact && q.sh == q.hold)
      else $error("previous result not sent during conversion");
   busy_cause_a: assert property (
      $rose(busy) |-> $past(cnv_fall) || ($past(q.st) == sarro_pkg::ST_ACQ))
      else $error("busy rose without a start");
   ovr_pulse_a: assert property (
      read_overrun_flag |=> !read_overrun_flag)
      else $error("read error longer than one cycle");
   ovr_at_end_a: assert property (
      conv_end && q.rdc_f && (q.sbits != FULL) |=> read_overrun_flag)
      else $error("unfinished read not flagged");
   sh_quiet_a: assert property (
      !rd_act && !q.mact && !n.mact && !conv_end |=> $stable(q.sh))
      else $error("shift register moved with no reader");
   par_drive_a: assert property (
      !ser && !q.s2[`SARRO_I_CS] && !q.s2[`SARRO_I_RD] |-> data_oe && !serial_data_oe)
      else $error("parallel bus not driven when read");
endmodule

// [sarro_params.svh]
// constants of the converter control and result readout block
// assumes a 250 MHz mclk; pin signals arrive asynchronous to it
`ifndef SARRO_PARAMS_SVH
`define SARRO_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SARRO_CLK_NS      4
`define SARRO_CONV_NS     4000
`define SARRO_ACQ_AUTO_NS 5600
`define SARRO_CONV_CYC    ((`SARRO_CONV_NS + `SARRO_CLK_NS - 1) / `SARRO_CLK_NS)
`define SARRO_ACQ_CYC     ((`SARRO_ACQ_AUTO_NS + `SARRO_CLK_NS - 1) / `SARRO_CLK_NS)
`define SARRO_PH_CYC      4
`define SARRO_CNT_W       12
// ----------------------------------------
// result word
// ----------------------------------------
`define SARRO_NBITS       16
`define SARRO_BITS_W      5
// ----------------------------------------
// positions in the synchronised pin vector
// ----------------------------------------
`define SARRO_PIN_N       11
`define SARRO_I_CNV       0
`define SARRO_I_CS        1
`define SARRO_I_RD        2
`define SARRO_I_SCK       3
`define SARRO_I_CHN       4
`define SARRO_I_PD        5
`define SARRO_I_SER       6
`define SARRO_I_EXT       7
`define SARRO_I_OCS       8
`define SARRO_I_INVC      9
`define SARRO_I_INVS      10
`endif

// [sarro_pkg.sv]
// types of the converter control and result readout block
// assumes sarro_params.svh is on the include path
`include "sarro_params.svh"
package sarro_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ACQ   = 2'b01,
      ST_CONV  = 2'b10,
      ST_MSEND = 2'b11
   } sarro_state_t;

   typedef struct packed {
      sarro_state_t                 st;
      logic [`SARRO_CNT_W-1:0]      cnt;
      logic [`SARRO_PIN_N-1:0]      s1;
      logic [`SARRO_PIN_N-1:0]      s2;
      logic [`SARRO_PIN_N-1:0]      s3;
      logic [`SARRO_NBITS-1:0]      hold;
      logic [`SARRO_NBITS-1:0]      sh;
      logic                         mact;
      logic [`SARRO_BITS_W-1:0]     mbits;
      logic [1:0]                   mph;
      logic [`SARRO_CNT_W-1:0]      mdiv;
      logic                         sclk;
      logic                         sync;
      logic [`SARRO_BITS_W-1:0]     sbits;
      logic                         rise_seen;
      logic                         chain;
      logic                         rdc_f;
      logic                         err;
   } sarro_regs_t;
endpackage

// [sarro_host.sv]
// host model: gated serial clock source and serial frame capture
// assumes the core's serial pins; its tasks are called from the bench
`timescale 1ns/1ns
module sarro_host (
   // clock
   input  wire logic mclk,
   // slave mode clock to the core
   output logic      sclk_in,
   // serial lines from the core
   input  wire logic serial_data_out,
   input  wire logic sclk_out,
   input  wire logic frame_strobe,
   input  wire logic serial_clock_invert,
   input  wire logic frame_strobe_invert,
   input  wire logic serial_data_oe
);
   logic sck_e;
   logic frm_e;
   logic sdo;
   // released data line reads as the inverse of the last bit
   assign sdo   = serial_data_oe ? serial_data_out : ~serial_data_out;
   assign sck_e = sclk_out ^ serial_clock_invert;
   assign frm_e = frame_strobe ^ frame_strobe_invert;
   initial sclk_in = 1'b0;
   // clock stands still between frames
   task automatic park(input logic lvl);
      sclk_in = lvl;
   endtask
   // gated 32 ns clock, bit taken late in the high phase
   task automatic slave_read(input int n, input logic hi, output logic [31:0] w);
      w = 32'h0;
      #1;
      sclk_in = 1'b0;
      #16;
      for (int i = 0; i < n; i++) begin
         sclk_in = 1'b1;
         #15;
         w = {w[30:0], sdo};
         #1;
         sclk_in = 1'b0;
         #16;
      end
      sclk_in = hi;
   endtask
   // bit taken on both edges of the generated clock
   task automatic master_read(output logic [15:0] wr, output logic [15:0] wf,
                              output logic fv);
      int t;
      t = 0;
      fv = 1'b1;
      while (frm_e !== 1'b1 && t < 3000) begin
         @(negedge mclk);
         t++;
      end
      for (int i = 15; i >= 0; i--) begin
         @(posedge sck_e);
         wr[i] = sdo;
         fv = fv & frm_e;
         @(negedge sck_e);
         wf[i] = sdo;
         fv = fv & frm_e;
      end
   endtask
endmodule

// [tb.sv]
// self-checking bench of the converter control and readout block
// assumes sarro_core and sarro_host are compiled before it
`timescale 1ns/1ns
module tb;
   localparam int CONV = 300;
   localparam int ACQ  = 30;
   localparam int FRM  = 256;
   logic        mclk, nrst, conversion_start_n, power_down_request, busy, powered_down;
   logic        output_coding_select, serial_parallel_select, clock_source_select;
   logic        serial_clock_invert, frame_strobe_invert, read_timing_or_chain_in;
   logic        cs_n, rd_n, data_oe, sclk_in, sclk_out, sclk_oe, frame_strobe;
   logic        serial_data_out, serial_data_oe, read_overrun_flag, fv;
   logic [15:0] adc_code, data_out, e, wr, wf;
   logic [31:0] sw;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          ovr_cnt = 0;
   int          w, t, n;
   sarro_core #(.CONV_CYC(12'h12c), .ACQ_CYC(12'h01e), .PH_CYC(12'h004)) u_sarro_core (
      .mclk, .nrst, .conversion_start_n, .power_down_request, .busy, .powered_down,
      .adc_code, .output_coding_select, .serial_parallel_select, .clock_source_select,
      .serial_clock_invert, .frame_strobe_invert, .read_timing_or_chain_in, .cs_n,
      .rd_n, .data_out, .data_oe, .sclk_in, .sclk_out, .sclk_oe, .frame_strobe,
      .serial_data_out, .serial_data_oe, .read_overrun_flag);
   sarro_host u_sarro_host (.mclk, .sclk_in, .serial_data_out, .sclk_out, .frame_strobe,
      .serial_clock_invert, .frame_strobe_invert, .serial_data_oe);
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) if (read_overrun_flag === 1'b1) ovr_cnt <= ovr_cnt + 1;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] coded(input logic [15:0] c, input logic ob);
      return ob ? c : {~c[15], c[14:0]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
      checks_done++;
      if (g !== x) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_busy(input logic lvl, output int c);
      c = 0;
      while (busy !== lvl && c < 5000) begin
         @(negedge mclk);
         c++;
      end
   endtask
   // start pulse, returns busy width in cycles
   task automatic conv(output int c);
      adc_code = 16'($urandom);
      conversion_start_n = 1'b0;
      repeat (2) @(negedge mclk);
      conversion_start_n = 1'b1;
      wait_busy(1'b1, c);
      wait_busy(1'b0, c);
   endtask
   task automatic par_read(input logic [15:0] x);
      for (int k = 3; k >= 0; k--) begin
         {cs_n, rd_n} = 2'(k);
         repeat (4) @(negedge mclk);
         chk("data_oe", k == 0, data_oe);
      end
      chk("data_out", x, data_oe ? data_out : ~data_out);
      {cs_n, rd_n} = 2'b11;
   endtask
   // about six times the expected run
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {conversion_start_n, cs_n, rd_n} = 3'h7;
      {power_down_request, output_coding_select, serial_parallel_select} = 3'h0;
      {clock_source_select, serial_clock_invert, frame_strobe_invert} = 3'h0;
      {read_timing_or_chain_in, adc_code, nrst} = 18'h0;
      void'($urandom(32'h052f));
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      chk("busy", 1'b0, busy);
      chk("data_out", 16'h0000, data_out);
      for (int i = 0; i < 4; i++) begin
         output_coding_select = i[0];
         conv(w);
         chk("busy_cycles", 16'(CONV), 16'(w));
         par_read(coded(adc_code, i[0]));
      end
      e = coded(adc_code, 1'b1);
      fork
         conv(w);
         begin
            repeat (10) @(negedge mclk);
            par_read(e);
         end
      join
      $display("test parallel done");
      fork
         conv(w);
         begin
            repeat (50) @(negedge mclk);
            conversion_start_n = 1'b0;
            power_down_request = 1'b1;
            repeat (8) @(negedge mclk);
            conversion_start_n = 1'b1;
            chk("powered_down", 1'b0, powered_down);
         end
      join
      chk("busy_cycles", 16'(CONV), 16'(w));
      repeat (ACQ + 20) @(negedge mclk);
      chk("busy", 1'b0, busy);
      chk("powered_down", 1'b1, powered_down);
      power_down_request = 1'b0;
      repeat (4) @(negedge mclk);
      conversion_start_n = 1'b0;
      wait_busy(1'b1, t);
      wait_busy(1'b0, t);
      wait_busy(1'b1, t);
      chk("acq_gap_ok", 1'b1, t >= ACQ - 1 && t <= ACQ + 2);
      conversion_start_n = 1'b1;
      wait_busy(1'b0, t);
      repeat (ACQ + 20) @(negedge mclk);
      chk("busy", 1'b0, busy);
      $display("test conversion control done");
      {serial_parallel_select, cs_n, rd_n} = 3'b100;
      for (int i = 0; i < 8; i++) begin
         {read_timing_or_chain_in, serial_clock_invert, frame_strobe_invert} = 3'(i);
         repeat (4) @(negedge mclk);
         fork
            conv(w);
            u_sarro_host.master_read(wr, wf, fv);
         join
         // read-after sends this conversion, read-during the one before
         if (i < 4) e = coded(adc_code, 1'b1);
         chk("sclk_oe", 1'b1, sclk_oe);
         chk("strobe_active", 1'b1, fv);
         chk("busy_cycles", 16'(i < 4 ? CONV + FRM : CONV), 16'(w));
         chk("sdo_rise", e, wr);
         chk("sdo_fall", e, wf);
         chk("sclk_idle", serial_clock_invert, sclk_out);
         chk("strobe_idle", frame_strobe_invert, frame_strobe);
         e = coded(adc_code, 1'b1);
      end
      $display("test master serial done");
      clock_source_select = 1'b1;
      for (int i = 0; i < 2; i++) begin
         {cs_n, rd_n} = 2'b11;
         u_sarro_host.park(i[0]);
         read_timing_or_chain_in = 1'($urandom);
         conv(w);
         {cs_n, rd_n} = 2'b00;
         repeat (4) @(negedge mclk);
         chk("sdo_oe", 1'b1, serial_data_oe);
         chk("sclk_oe", 1'b0, sclk_oe);
         u_sarro_host.slave_read(17, i[0], sw);
         chk("slave_word", coded(adc_code, 1'b1), sw[16:1]);
         chk("chain_bit", read_timing_or_chain_in, sw[0]);
      end
      {cs_n, rd_n} = 2'b11;
      read_timing_or_chain_in = 1'b0;
      u_sarro_host.park(1'b0);
      conv(w);
      e = coded(adc_code, 1'b1);
      {cs_n, rd_n} = 2'b00;
      for (int m = 16; m > 0; m -= 13) begin
         n = ovr_cnt;
         fork
            conv(w);
            begin
               wait_busy(1'b1, t);
               u_sarro_host.slave_read(m, 1'b0, sw);
            end
         join
         repeat (4) @(negedge mclk);
         if (m == 16) chk("during_word", e, sw[15:0]);
         chk("overrun_pulses", 16'(m < 16), 16'(ovr_cnt - n));
      end
      $display("test slave serial done");
      end_of_test();
   end
endmodule
